// File: rtl/b2s_params.svh
`ifndef B2S_PARAMS_SVH
`define B2S_PARAMS_SVH

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define B2S_DW          18
`define B2S_AW          19
`define B2S_DW_WIDE     36
`define B2S_AW_MAX      19
`define B2S_LANE_W      9
`define B2S_MAX_LANES   4
`define B2S_RING_AW     2

// ---------------------------------------------------------------
// Strap timing on the main clock
// ---------------------------------------------------------------
`define B2S_MCLK_MHZ       125
`define B2S_STRAP_HOLD_NS  128
`define B2S_STRAP_WIN_NS   1024
`define B2S_STRAP_CYC      ((`B2S_STRAP_HOLD_NS * `B2S_MCLK_MHZ + 999) / 1000)
`define B2S_STRAP_WIN_CYC  ((`B2S_STRAP_WIN_NS * `B2S_MCLK_MHZ) / 1000)
`define B2S_STRAP_CW       8

`endif

// File: rtl/b2s_pkg.sv
`include "b2s_params.svh"

package b2s_pkg;

   // ------------------------------------------------------------
   // Read output sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      B2S_O_IDLE  = 2'b01,
      B2S_O_BURST = 2'b10
   } b2s_ostate_e;

   // ------------------------------------------------------------
   // Write request caught at the positive input clock rise
   // ------------------------------------------------------------
   typedef struct packed {
      logic                        pend;
      logic [`B2S_MAX_LANES-1:0]   keep_n;
   } b2s_wr_ctl_s;

endpackage : b2s_pkg

// File: rtl/b2s_sram_port.sv
`include "b2s_params.svh"

module b2s_sram_port
   import b2s_pkg::*;
#(
   parameter int DW = `B2S_DW,
   parameter int AW = `B2S_AW
) (
   // Main clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // Input clock pair; K-bar rise is taken as the K fall
   input  wire logic          k_clk,
   // Output clock pair; C-bar rise is taken as the C fall
   input  wire logic          c_clk,
   input  wire logic          c_n_clk,
   // Shared address
   input  wire logic [AW-1:0] addr,
   // Write port
   input  wire logic          write_port_select_n,
   input  wire logic [DW/`B2S_LANE_W-1:0] byte_write_select_n,
   input  wire logic [DW-1:0] wdata,
   // Read port
   input  wire logic          read_port_select_n,
   output logic      [DW-1:0] rdata,
   output logic               rdata_oe,
   // Strap status
   output logic               single_clock_mode
);

   localparam int LANES = DW / `B2S_LANE_W;
   localparam int RAW   = `B2S_RING_AW;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (DW != `B2S_DW && DW != `B2S_DW_WIDE) begin : g_bad_dw
      $error("Data width must be the narrow or the wide variant.");
   end
   if (AW < 1 || AW > `B2S_AW_MAX) begin : g_bad_aw
      $error("Address width out of range.");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [2*DW-1:0]        mem [0:(1<<AW)-1];
   logic [2*DW-1:0]        ring [0:(1<<RAW)-1];
   logic                   k_rst_s1, k_rst_n_reg;
   logic                   o_rst_s1, o_rst_n_reg;
   b2s_wr_ctl_s            wr_ctl_reg, wr_ctl_next;
   logic [DW-1:0]          wdata0_reg;
   logic [2*DW-1:0]        wr_old, wr_merged;
   logic [7:0]             wr_done_cnt;
   logic                   rd_go_reg;
   logic [AW-1:0]          rd_addr_reg, rd_addr_next;
   logic [RAW-1:0]         wp_bin_reg, wp_gray_reg, wp_bin_next;
   logic                   o_clk;
   logic [RAW-1:0]         wp_s1, wp_s2;
   logic [RAW-1:0]         rp_bin_reg, rp_gray_reg, rp_bin_next;
   logic                   rd_avail;
   b2s_ostate_e            ostate_reg, ostate_next;
   logic [DW-1:0]          q_pos_reg, q_neg_reg, w1_reg;
   logic [1:0]             cs1, cs2, cs3;
   logic                   strap_hi;
   logic [`B2S_STRAP_CW-1:0] hi_cnt_reg, win_cnt_reg;
   logic                   single_reg;

   // ---------------------------------------------------------------
   // Reset synchronisers for the link domains
   // ---------------------------------------------------------------
   // Assert at once, release on the link clock so no flop leaves reset mid-edge.
   always_ff @(posedge k_clk or negedge rst_n) begin
      if (!rst_n) begin
         k_rst_s1    <= 1'b0;
         k_rst_n_reg <= 1'b0;
      end else begin
         k_rst_s1    <= 1'b1;
         k_rst_n_reg <= k_rst_s1;
      end
   end

   always_ff @(posedge o_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rst_s1    <= 1'b0;
         o_rst_n_reg <= 1'b0;
      end else begin
         o_rst_s1    <= 1'b1;
         o_rst_n_reg <= o_rst_s1;
      end
   end

   // ---------------------------------------------------------------
   // Write port
   // ---------------------------------------------------------------
   // Request and lane selects of the first word, caught at the K rise.
   always_comb begin
      wr_ctl_next                    = '0;
      wr_ctl_next.pend               = !write_port_select_n;
      wr_ctl_next.keep_n             = '1;
      wr_ctl_next.keep_n[LANES-1:0]  = byte_write_select_n;
   end

   always_ff @(posedge k_clk or negedge k_rst_n_reg) begin
      if (!k_rst_n_reg) begin
         wr_ctl_reg <= '0;
         wdata0_reg <= '0;
      end else begin
         wr_ctl_reg <= wr_ctl_next;
         wdata0_reg <= wdata;
      end
   end

   // Lane merge: a deselected lane keeps the stored bits of its word.
   assign wr_old = mem[addr];
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign wr_merged[l*`B2S_LANE_W +: `B2S_LANE_W] =
         wr_ctl_reg.keep_n[l] ? wr_old[l*`B2S_LANE_W +: `B2S_LANE_W]
                              : wdata0_reg[l*`B2S_LANE_W +: `B2S_LANE_W];
      assign wr_merged[DW + l*`B2S_LANE_W +: `B2S_LANE_W] =
         byte_write_select_n[l] ? wr_old[DW + l*`B2S_LANE_W +: `B2S_LANE_W]
                                : wdata[l*`B2S_LANE_W +: `B2S_LANE_W];
   end

   // The K-bar rise takes the address and second word and stores both.
   // Without a pending request nothing is stored, though every K rise still registers the first word.
   always_ff @(negedge k_clk) begin
      if (wr_ctl_reg.pend) begin
         mem[addr] <= wr_merged;
      end
   end

   // Count of completed writes, kept for the checks below.
   always_ff @(negedge k_clk or negedge k_rst_n_reg) begin
      if (!k_rst_n_reg) begin
         wr_done_cnt <= '0;
      end else if (wr_ctl_reg.pend) begin
         wr_done_cnt <= 8'(wr_done_cnt + 8'h01);
      end
   end

   // ---------------------------------------------------------------
   // Read port, input side
   // ---------------------------------------------------------------
   // The address register only moves when the read port is selected.
   assign rd_addr_next = !read_port_select_n ? addr : rd_addr_reg;
   assign wp_bin_next  = wp_bin_reg + RAW'(1);

   always_ff @(posedge k_clk or negedge k_rst_n_reg) begin
      if (!k_rst_n_reg) begin
         rd_go_reg   <= 1'b0;
         rd_addr_reg <= '0;
         wp_bin_reg  <= '0;
         wp_gray_reg <= '0;
      end else begin
         rd_go_reg   <= !read_port_select_n;
         rd_addr_reg <= rd_addr_next;
         if (rd_go_reg) begin
            wp_bin_reg  <= wp_bin_next;
            wp_gray_reg <= wp_bin_next ^ (wp_bin_next >> 1);
         end
      end
   end

   // Both words of one location travel as one ring entry, so a burst is
   // always a pair. Read one K cycle after the request, past the K-bar write.
   always_ff @(posedge k_clk) begin
      if (rd_go_reg) begin
         ring[wp_bin_reg] <= mem[rd_addr_reg];
      end
   end

   // ---------------------------------------------------------------
   // Read port, output side
   // ---------------------------------------------------------------
   // The strap is settled long before any read, so the clock choice is static.
   assign o_clk = single_clock_mode ? k_clk : c_clk;

   // Gray pointer crossing; the ring lets reads run back to back even
   // though the crossing adds latency against the input clock.
   always_ff @(posedge o_clk or negedge o_rst_n_reg) begin
      if (!o_rst_n_reg) begin
         wp_s1 <= '0;
         wp_s2 <= '0;
      end else begin
         wp_s1 <= wp_gray_reg;
         wp_s2 <= wp_s1;
      end
   end

   assign rd_avail    = (wp_s2 != rp_gray_reg);
   assign rp_bin_next = rp_bin_reg + RAW'(1);
   assign ostate_next = rd_avail ? B2S_O_BURST : B2S_O_IDLE;

   always_ff @(posedge o_clk or negedge o_rst_n_reg) begin
      if (!o_rst_n_reg) begin
         ostate_reg  <= B2S_O_IDLE;
         rp_bin_reg  <= '0;
         rp_gray_reg <= '0;
      end else begin
         ostate_reg <= ostate_next;
         if (rd_avail) begin
            rp_bin_reg  <= rp_bin_next;
            rp_gray_reg <= rp_bin_next ^ (rp_bin_next >> 1);
         end
      end
   end

   // Low word on the C rise, second word held for the C-bar rise.
   always_ff @(posedge o_clk or negedge o_rst_n_reg) begin
      if (!o_rst_n_reg) begin
         q_pos_reg <= '0;
         w1_reg    <= '0;
      end else if (rd_avail) begin
         q_pos_reg <= ring[rp_bin_reg][DW-1:0];
         w1_reg    <= ring[rp_bin_reg][2*DW-1:DW];
      end
   end

   always_ff @(negedge o_clk or negedge o_rst_n_reg) begin
      if (!o_rst_n_reg) begin
         q_neg_reg <= '0;
      end else begin
         q_neg_reg <= w1_reg;
      end
   end

   // DDR output: the clock phase picks which registered word is shown.
   assign rdata    = o_clk ? q_pos_reg : q_neg_reg;
   assign rdata_oe = (ostate_reg == B2S_O_BURST);

   // ---------------------------------------------------------------
   // Single clock strap on the main clock
   // ---------------------------------------------------------------
   // Running output clocks are never both high for long; tied pins are.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cs1 <= '0;
         cs2 <= '0;
         cs3 <= '0;
      end else begin
         cs1 <= {c_clk, c_n_clk};
         cs2 <= cs1;
         cs3 <= cs2;
      end
   end

   assign strap_hi = (cs2 == cs3) && (&cs3);

   // Decided once inside a window after reset, then frozen.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt_reg  <= '0;
         win_cnt_reg <= '0;
         single_reg  <= 1'b0;
      end else if (win_cnt_reg != `B2S_STRAP_CW'(`B2S_STRAP_WIN_CYC)) begin
         win_cnt_reg <= win_cnt_reg + `B2S_STRAP_CW'(1);
         hi_cnt_reg  <= strap_hi ? hi_cnt_reg + `B2S_STRAP_CW'(1) : '0;
         if (strap_hi && hi_cnt_reg == `B2S_STRAP_CW'(`B2S_STRAP_CYC - 1)) begin
            single_reg <= 1'b1;
         end
      end
   end

   assign single_clock_mode = single_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_wr_start: assert property (@(posedge k_clk) disable iff (!k_rst_n_reg)
      !write_port_select_n |=> wr_done_cnt == 8'($past(wr_done_cnt) + 8'h01))
      else $error("Selected write did not store.");

   a_wr_ignored: assert property (@(posedge k_clk) disable iff (!k_rst_n_reg)
      write_port_select_n |=> $stable(wr_done_cnt))
      else $error("Deselected write port stored data.");

   a_lane_keep: assert property (@(negedge k_clk) disable iff (!k_rst_n_reg)
      wr_ctl_reg.pend && byte_write_select_n[0]
      |-> wr_merged[DW +: `B2S_LANE_W] == wr_old[DW +: `B2S_LANE_W])
      else $error("Deselected lane was altered.");

   a_lane_write: assert property (@(negedge k_clk) disable iff (!k_rst_n_reg)
      wr_ctl_reg.pend && !wr_ctl_reg.keep_n[0]
      |-> wr_merged[`B2S_LANE_W-1:0] == wdata0_reg[`B2S_LANE_W-1:0])
      else $error("Selected lane of first word not written.");

   a_rd_capture: assert property (@(posedge k_clk) disable iff (!k_rst_n_reg)
      !read_port_select_n |=> rd_go_reg && rd_addr_reg == $past(addr))
      else $error("Read address not captured.");

   a_rd_ignore: assert property (@(posedge k_clk) disable iff (!k_rst_n_reg)
      read_port_select_n |=> !rd_go_reg && $stable(rd_addr_reg))
      else $error("Deselected read moved the address.");

   a_rd_ring: assert property (@(posedge k_clk) disable iff (!k_rst_n_reg)
      !read_port_select_n |=> ##1 wp_bin_reg == RAW'($past(wp_bin_reg) + 1'b1))
      else $error("Read request lost.");

   a_burst_word: assert property (@(posedge o_clk) disable iff (!o_rst_n_reg)
      rd_avail |=> rdata_oe && q_pos_reg == $past(ring[rp_bin_reg][DW-1:0]))
      else $error("Low word not presented.");

   // The second word must be staged from the same ring entry as the first.
   a_burst_pair: assert property (@(posedge o_clk) disable iff (!o_rst_n_reg)
      rd_avail |=> w1_reg == $past(ring[rp_bin_reg][2*DW-1:DW]))
      else $error("Second word of the burst not staged.");

   a_oe_drop: assert property (@(posedge o_clk) disable iff (!o_rst_n_reg)
      !rd_avail |=> !rdata_oe)
      else $error("Outputs driven without a pending burst.");

   a_strap_set: assert property (@(posedge mclk) disable iff (!rst_n)
      !single_reg && strap_hi && win_cnt_reg != `B2S_STRAP_CW'(`B2S_STRAP_WIN_CYC)
      && hi_cnt_reg == `B2S_STRAP_CW'(`B2S_STRAP_CYC - 1) |=> single_reg)
      else $error("Strap held high not recognised.");

   c_write: cover property (@(posedge k_clk) !write_port_select_n);
   c_read: cover property (@(posedge o_clk) $rose(rdata_oe));
   c_both: cover property (@(posedge k_clk)
      !write_port_select_n && !read_port_select_n);
   c_partial: cover property (@(negedge k_clk)
      wr_ctl_reg.pend && byte_write_select_n[0] && !wr_ctl_reg.keep_n[0]);

endmodule : b2s_sram_port

// File: testbench/b2s_ctl_model.sv
`include "b2s_params.svh"

module b2s_ctl_model #(
   parameter int DW = `B2S_DW,
   parameter int AW = `B2S_AW,
   parameter int SKEW_NS = 37
) (
   // Main clock and strap request
   input  wire logic                 mclk,
   input  wire logic                 strap_high,
   // Clock pairs
   output logic                      k_clk,
   output logic                      c_clk,
   output logic                      c_n_clk,
   // Requests
   output logic [AW-1:0]             addr,
   output logic                      write_port_select_n,
   output logic [DW/`B2S_LANE_W-1:0] byte_write_select_n,
   output logic [DW-1:0]             wdata,
   output logic                      read_port_select_n
);
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------
   // Controller clocks and requests
   // ---------------------------------------------------------
   logic c_del;

   // The input clock runs free; a 1 ns offset keeps its edges off the main clock.
   initial begin
      k_clk = 1'b0;
      c_del = 1'b0;
      addr = '0;
      write_port_select_n = 1'b1;
      read_port_select_n = 1'b1;
      byte_write_select_n = '1;
      wdata = '0;
      #1;
      forever begin
         #80 k_clk = ~k_clk;
      end
   end

   // The output clock lags the input clock, as a board deskew would place it.
   always @(k_clk) begin
      c_del <= #(SKEW_NS) k_clk;
   end

   // Both output clocks held high ask for single clock mode.
   assign c_clk   = strap_high | c_del;
   assign c_n_clk = strap_high | ~c_del;

   // One input clock cycle of requests; released lines show their inverse.
   task automatic access(input logic wr, input logic rd, input logic [AW-1:0] wa,
                         input logic [AW-1:0] ra, input logic [DW-1:0] w0,
                         input logic [DW-1:0] w1, input logic [DW/`B2S_LANE_W-1:0] b0,
                         input logic [DW/`B2S_LANE_W-1:0] b1);
      @(negedge k_clk);
      @(negedge mclk);
      write_port_select_n = ~wr;
      read_port_select_n = ~rd;
      addr = ra;
      wdata = w0;
      byte_write_select_n = b0;
      @(posedge k_clk);
      @(negedge mclk);
      write_port_select_n = 1'b1;
      read_port_select_n = 1'b1;
      addr = wa;
      wdata = w1;
      byte_write_select_n = b1;
      @(negedge k_clk);
      @(negedge mclk);
      addr = ~wa;
      wdata = ~w1;
      byte_write_select_n = ~b1;
   endtask : access
endmodule : b2s_ctl_model

// File: testbench/b2s_sram_port_tb_top.sv
`include "b2s_params.svh"

module b2s_sram_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------
   // Bench signals
   // ---------------------------------------------------------
   localparam int DW = `B2S_DW;
   localparam int AW = `B2S_AW;
   localparam int LW = `B2S_LANE_W;
   localparam int NL = DW / LW;
   localparam logic [AW-1:0] A_LO = '0;
   localparam logic [AW-1:0] A_HI = '1;

   logic            mclk;
   logic            rst_n;
   logic            strap_high;
   logic            k_clk;
   logic            c_clk;
   logic            c_n_clk;
   logic [AW-1:0]   addr;
   logic            write_port_select_n;
   logic [NL-1:0]   byte_write_select_n;
   logic [DW-1:0]   wdata;
   logic            read_port_select_n;
   logic [DW-1:0]   rdata;
   logic            rdata_oe;
   logic            single_clock_mode;
   logic            o_clk;
   int              num_errors;
   int              comparisons;
   logic [2*DW-1:0] shadow [int];

   // Main clock, and the clock that times read data in the current mode.
   always #4 mclk = ~mclk;
   assign o_clk = single_clock_mode ? k_clk : c_clk;

   b2s_ctl_model #(.DW(DW), .AW(AW)) i_ctl (.mclk(mclk), .strap_high(strap_high),
      .k_clk(k_clk), .c_clk(c_clk), .c_n_clk(c_n_clk), .addr(addr),
      .write_port_select_n(write_port_select_n), .byte_write_select_n(byte_write_select_n),
      .wdata(wdata), .read_port_select_n(read_port_select_n));

   b2s_sram_port #(.DW(DW), .AW(AW)) i_dut (.mclk(mclk), .rst_n(rst_n), .k_clk(k_clk),
      .c_clk(c_clk), .c_n_clk(c_n_clk), .addr(addr),
      .write_port_select_n(write_port_select_n), .byte_write_select_n(byte_write_select_n),
      .wdata(wdata), .read_port_select_n(read_port_select_n), .rdata(rdata),
      .rdata_oe(rdata_oe), .single_clock_mode(single_clock_mode));

   // Verdict and end of run.
   task automatic close_out();
      $display("Counts: %0d comparisons, %0d errors", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("Error at %0t ns: %s", $time, msg);
      end
   endtask : check

   // Bounded wait on the output enable or on the output clock.
   task automatic wait_on(input bit sel_oe, input logic val);
      int n;
      n = 0;
      while ((sel_oe ? rdata_oe : o_clk) !== val && n < 150) begin
         @(negedge mclk);
         n++;
      end
      if ((sel_oe ? rdata_oe : o_clk) !== val) begin
         check(1'b0, "wait ran out");
         close_out();
      end
   endtask : wait_on

   // Long hold: the link clocks are far slower than the main clock.
   task automatic do_reset(input logic strap);
      @(negedge mclk);
      rst_n = 1'b0;
      strap_high = strap;
      repeat (16) @(negedge mclk);
      repeat (3) @(posedge k_clk);
      check(rdata_oe === 1'b0, "outputs driven in reset");
      @(negedge mclk);
      rst_n = 1'b1;
      repeat (200) @(negedge mclk);
      check(single_clock_mode === strap, "strap reading wrong");
   endtask : do_reset

   task automatic collect(input logic [2*DW-1:0] exp);
      wait_on(1'b1, 1'b1);
      repeat (2) @(negedge mclk);
      check(o_clk === 1'b1 && rdata === exp[DW-1:0], "first word wrong");
      wait_on(1'b0, 1'b0);
      repeat (2) @(negedge mclk);
      check(rdata_oe === 1'b1 && rdata === exp[2*DW-1:DW], "second word wrong");
      wait_on(1'b1, 1'b0);
      check(o_clk === 1'b1, "outputs not floated at clock rise");
   endtask : collect

   // One request cycle; the shadow copy follows the lane selects.
   task automatic xfer(input logic wr, input logic rd, input logic [AW-1:0] wa,
                       input logic [AW-1:0] ra, input logic [DW-1:0] w0,
                       input logic [DW-1:0] w1, input logic [NL-1:0] b0,
                       input logic [NL-1:0] b1);
      logic [2*DW-1:0] exp;
      exp = shadow[int'(ra)];
      i_ctl.access(wr, rd, wa, ra, w0, w1, b0, b1);
      for (int l = 0; l < NL; l++) begin
         if (wr && !b0[l]) shadow[int'(wa)][l*LW +: LW] = w0[l*LW +: LW];
         if (wr && !b1[l]) shadow[int'(wa)][DW+l*LW +: LW] = w1[l*LW +: LW];
      end
      if (rd) collect(exp);
   endtask : xfer

   task automatic t_basic();
      xfer(1'b1, 1'b0, A_HI, A_LO, 18'h2a5c3, 18'h15a3c, '0, '0);
      xfer(1'b1, 1'b0, A_LO, A_HI, 18'h0f0f0, 18'h30303, '0, '0);
      xfer(1'b0, 1'b1, A_LO, A_HI, '0, '0, '1, '1);
      xfer(1'b0, 1'b1, A_HI, A_LO, '0, '0, '1, '1);
      $display("basic test done");
   endtask : t_basic

   task automatic t_lanes();
      xfer(1'b1, 1'b0, A_HI, A_LO, 18'h3ffff, 18'h3ffff, 2'b01, 2'b10);
      xfer(1'b0, 1'b1, A_LO, A_HI, '0, '0, '1, '1);
      $display("lane test done");
   endtask : t_lanes

   task automatic t_deselect();
      xfer(1'b0, 1'b0, A_LO, A_HI, 18'h12345, 18'h2bcde, '0, '0);
      xfer(1'b0, 1'b1, A_HI, A_LO, '0, '0, '1, '1);
      $display("deselect test done");
   endtask : t_deselect

   task automatic t_concurrent();
      xfer(1'b1, 1'b1, A_LO, A_HI, 18'h01234, 18'h23456, '0, '0);
      xfer(1'b0, 1'b1, A_HI, A_LO, '0, '0, '1, '1);
      $display("concurrent test done");
   endtask : t_concurrent

   task automatic t_single();
      do_reset(1'b1);
      xfer(1'b0, 1'b1, A_LO, A_HI, '0, '0, '1, '1);
      $display("single clock test done");
   endtask : t_single

   // Main sequence.
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      strap_high = 1'b0;
      num_errors = 0;
      comparisons = 0;
      do_reset(1'b0);
      t_basic();
      t_lanes();
      t_deselect();
      t_concurrent();
      t_single();
      close_out();
   end
endmodule : b2s_sram_port_tb_top
